// ==== hdl/ffh_ctrl.sv ====
/*
  Fault flag and halt-on-fault control with a Wishbone register slave.
  Assumes the core gives one-cycle event pulses on clk_i, the address of the
  executing instruction on ip_i, and a pulse at each descheduling point.
  Pins upstream_fault_in_i and debug_halt_i are asynchronous.
*/
// Implementation choices: the Wishbone register port and the register addresses.
// Operation
// RULE1 - Fault pin is internal fault flag ORed with upstream fault input.
// RULE2 - Overflow, divide by zero, bounds, software set or FPU set the fault flag.
// RULE3 - Fault flag stays set until the test-and-clear instruction runs.
// RULE4 - Processor reset does not change the fault flag.
// RULE5 - Fault rising with stop armed halts this device only.
// RULE6 - Arming stop with fault already set does not halt.
// RULE7 - Pre-emption saves both flags, passes them on, restores at end.
// RULE8 - High priority flag changes do not disturb the pre-empted process.
// RULE9 - On fault halt, links finish outstanding transfers then go idle.
// RULE10 - Debug halt: input links continue, output links fetch no more data; the code raises link_quiesce_o in this halt as well.
// RULE11 - Memory refresh continues while halted.
// RULE12 - Fault halt leaves pointer two bytes past the faulting instruction.
// RULE13 - Debug halt leaves pointer one byte past; pointer copied to top stack.
// RULE14 - Outside logic must not assume a fault flag value at power up.
// RULE15 - Fault pins may be chained to a master's event request input.
// RULE16 - Debug halt request stops the device at the next descheduling point.
// RULE17 - Reset with debug halt held leaves fault, stop, breakpoint flags alone.
`timescale 1ns/1ns
`include "ffh_params.svh"
module ffh_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins
  input  wire logic        upstream_fault_in_i,
  input  wire logic        debug_halt_i,
  output logic             fault_o,
  // Core events
  input  wire logic        proc_reset_i,
  input  wire logic        ovf_i,
  input  wire logic        div0_i,
  input  wire logic        bounds_i,
  input  wire logic        fpu_fault_i,
  input  wire logic        core_set_i,
  input  wire logic        test_clr_i,
  input  wire logic        preempt_i,
  input  wire logic        preempt_end_i,
  input  wire logic        desched_i,
  input  wire logic [31:0] ip_i,
  input  wire logic        links_busy_i,
  // Core controls
  output logic             stop_procs_o,
  output logic             link_quiesce_o,
  output logic             out_fetch_inhibit_o,
  output logic             refresh_en_o,
  output logic             areg_load_o,
  output logic      [31:0] areg_o,
  output logic             test_result_o,
  output logic             stop_on_fault_flag_o,
  output logic             breakpoint_enable_flag_o,
  // Interrupt
  output logic             irq_o
);

  typedef struct packed {
    ffh_pkg::ffh_state_t         st;
    logic                        fault;
    logic                        stop;
    logic                        bkpt;
    logic                        fault_pin;
    logic                        halted;
    logic                        dbg_halt;
    logic                        quiesce;
    logic                        fetch_inh;
    logic                        refresh;
    logic [31:0]                 halt_ip;
    logic                        areg_ld;
    logic                        tres;
    logic                        up_q;
    logic                        saved;
    logic [`FFH_IRQ_W-1:0]       irq_st;
    logic [`FFH_IRQ_W-1:0]       irq_mask;
    logic                        irq;
    logic                        ack;
    logic [31:0]                 rdat;
  } ffh_main_t;

  // Present and next state of the whole block
  ffh_main_t s;
  ffh_main_t next_s;

  // Synchronised pin levels and the saved low priority flags
  logic       up_sync;
  logic       dbg_sync;
  logic       sv_fault;
  logic       sv_stop;
  logic       sv_held;

  // Pins cross into clk_i through two flops
  ffh_sync #(
    .W (2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({upstream_fault_in_i, debug_halt_i}),
    .q_o   ({up_sync, dbg_sync})
  );

  // Low priority flag copy across pre-emption
  ffh_save u_save (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .save_i  (preempt_i),
    .fault_i (s.fault),
    .stop_i  (s.stop),
    .fault_o (sv_fault),
    .stop_o  (sv_stop),
    .held_o  (sv_held)
  );

  // Byte-address match on an aligned word
  // Bits 1:0 are ignored, so any byte address inside a word selects it
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = ({adr[7:2], 2'b00} == off);
  endfunction

  // Halt states; any other code counts as running
  function automatic logic is_halt(input ffh_pkg::ffh_state_t st);
    is_halt = (st == ffh_pkg::FFH_HALT_FLT) | (st == ffh_pkg::FFH_HALT_DBG);
  endfunction

  // Decoded strobes and event terms of the current cycle
  logic       req;
  logic       wr;
  logic       rd;
  logic       set_any;
  logic       clr_any;
  logic       rise;
  logic       fault_halt;
  logic       run;
  logic       rd_irq;
  logic [`FFH_IRQ_W-1:0] irq_set;
  logic [31:0] stat_word;

  // Bus request decode; ack is held off one cycle so each access acks once
  // Writes need byte lane 0, since every writable field sits in it
  always_comb
  begin
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    wr  = req & wb_we_i & wb_sel_i[0];
    rd  = req & ~wb_we_i;
  end

  // Fault sources and the test-and-clear command
  always_comb
  begin
    set_any = ovf_i | div0_i | bounds_i | fpu_fault_i | core_set_i        // [RULE2]
            | (wr & reg_hit(wb_adr_i, `FFH_CMD_OFF) & wb_dat_i[`FFH_CMD_SET]);
    clr_any = test_clr_i
            | (wr & reg_hit(wb_adr_i, `FFH_CMD_OFF) & wb_dat_i[`FFH_CMD_TCLR]);
    // Only a zero to one change of the flag can halt
    rise       = ~s.fault & set_any;                                    // [RULE6]
    run        = ~is_halt(s.st);
    fault_halt = run & s.stop & rise;                                   // [RULE5]
    rd_irq     = rd & reg_hit(wb_adr_i, `FFH_IRQ_STAT_OFF);
  end

  // Status word seen by software
  // Links idle is live, so software can poll it while a halt drains
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`FFH_STAT_FAULT]  = s.fault;
    stat_word[`FFH_STAT_STOP]   = s.stop;
    stat_word[`FFH_STAT_HALTED] = s.halted;
    stat_word[`FFH_STAT_DBG]    = s.dbg_halt;
    stat_word[`FFH_STAT_IDLE]   = s.quiesce & ~links_busy_i;
    stat_word[`FFH_STAT_TRES]   = s.tres;
  end

  // Main next-state process
  always_comb
  begin
    next_s         = s;
    next_s.areg_ld = 1'b0;
    next_s.ack     = req;
    next_s.up_q    = up_sync;

    // Save and restore pair up; a stray end of pre-emption restores nothing
    if (preempt_i)
      next_s.saved = 1'b1;
    else if (preempt_end_i)
      next_s.saved = 1'b0;

    // Sticky fault flag: a set in the clear cycle wins
    // The test result keeps the flag as it stood before the clear
    if (clr_any)
      next_s.tres = s.fault;
    if (preempt_end_i & sv_held & s.saved)
    begin
      // Low priority status comes back whatever the high one did
      next_s.fault = sv_fault | set_any;                                // [RULE7] [RULE8]
      next_s.stop  = sv_stop;                                           // [RULE7]
    end
    else
      next_s.fault = (s.fault & ~clr_any) | set_any;                    // [RULE3]

    // Control register write
    if (wr & reg_hit(wb_adr_i, `FFH_CTRL_OFF))
    begin
      next_s.stop = wb_dat_i[`FFH_CTRL_STOP];
      next_s.bkpt = wb_dat_i[`FFH_CTRL_BKPT];
    end
    // A new mask reaches the interrupt output on the same edge
    if (wr & reg_hit(wb_adr_i, `FFH_IRQ_MASK_OFF))
      next_s.irq_mask = wb_dat_i[`FFH_IRQ_W-1:0];

    // Halt sequencer
    case (s.st)
      ffh_pkg::FFH_RUN:
      begin
        if (fault_halt)
          next_s.st = ffh_pkg::FFH_HALT_FLT;
        else if (dbg_sync)
          next_s.st = ffh_pkg::FFH_WAIT_DS;                             // [RULE16]
      end
      ffh_pkg::FFH_WAIT_DS:
      begin
        if (fault_halt)
          next_s.st = ffh_pkg::FFH_HALT_FLT;
        else if (desched_i)
          next_s.st = ffh_pkg::FFH_HALT_DBG;                            // [RULE16]
        else if (!dbg_sync)
          next_s.st = ffh_pkg::FFH_RUN;                                 // Request withdrawn
      end
      // Halts hold; only the processor reset below restarts the sequencer
      ffh_pkg::FFH_HALT_FLT:
        next_s.st = ffh_pkg::FFH_HALT_FLT;
      ffh_pkg::FFH_HALT_DBG:
        next_s.st = ffh_pkg::FFH_HALT_DBG;
      default:
        next_s.st = ffh_pkg::FFH_RUN;
    endcase

    // Pointer capture on entry to a halt
    // Only the entry edge loads the stack register; later cycles hold the pointer
    if (fault_halt)
    begin
      next_s.halt_ip = ip_i + `FFH_FAULT_IP_ADJ;                        // [RULE12]
      next_s.areg_ld = 1'b1;                                            // [RULE13]
    end
    else if ((s.st == ffh_pkg::FFH_WAIT_DS) & desched_i)
    begin
      next_s.halt_ip = ip_i + `FFH_DBG_IP_ADJ;                          // [RULE13]
      next_s.areg_ld = 1'b1;
      next_s.dbg_halt = 1'b1;
    end

    // Processor reset restarts the sequencer; the fault flag is untouched
    // A debug halt held through the reset keeps the flags for analysis
    if (proc_reset_i)
    begin
      next_s.st       = ffh_pkg::FFH_RUN;                               // [RULE4]
      next_s.dbg_halt = 1'b0;
      if (!dbg_sync)
      begin
        next_s.stop = 1'b0;                                             // [RULE17]
        next_s.bkpt = 1'b0;
      end
    end

    // Registered outputs derived from the next state
    // so each output flop moves on the same edge as the state flop
    next_s.halted    = is_halt(next_s.st);
    next_s.quiesce   = next_s.halted;                                   // [RULE9]
    next_s.fetch_inh = next_s.halted & (dbg_sync | next_s.dbg_halt);    // [RULE10]
    next_s.refresh   = `FFH_REFRESH_RST;                                // [RULE11]
    next_s.fault_pin = next_s.fault | up_sync;                          // [RULE1]

    // Sticky interrupt status; a new event beats the read clear
    // The halt bit marks entry only, not the time spent halted
    irq_set = '0;
    irq_set[`FFH_IRQ_FAULT]    = rise;
    irq_set[`FFH_IRQ_HALT]     = next_s.halted & ~s.halted;
    irq_set[`FFH_IRQ_UPSTREAM] = up_sync & ~s.up_q;
    next_s.irq_st = (rd_irq ? '0 : s.irq_st) | irq_set;
    next_s.irq    = |(next_s.irq_st & next_s.irq_mask);

    // Read data; unmapped addresses read zero
    // The command register is write only and so reads as zero
    next_s.rdat = 32'h0000_0000;
    if (rd)
    begin
      if (reg_hit(wb_adr_i, `FFH_CTRL_OFF))
      begin
        next_s.rdat[`FFH_CTRL_STOP] = s.stop;
        next_s.rdat[`FFH_CTRL_BKPT] = s.bkpt;
      end
      else if (reg_hit(wb_adr_i, `FFH_STAT_OFF))
        next_s.rdat = stat_word;
      else if (reg_hit(wb_adr_i, `FFH_HALT_IP_OFF))
        next_s.rdat = s.halt_ip;
      else if (reg_hit(wb_adr_i, `FFH_IRQ_STAT_OFF))
        next_s.rdat[`FFH_IRQ_W-1:0] = s.irq_st;
      else if (reg_hit(wb_adr_i, `FFH_IRQ_MASK_OFF))
        next_s.rdat[`FFH_IRQ_W-1:0] = s.irq_mask;
    end
  end

  // State register; the fault flag is cleared only by the system reset so
  // simulation starts defined, yet the pin watchers must not rely on it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s          <= '0;
      s.st       <= ffh_pkg::FFH_RUN;
      s.refresh  <= `FFH_REFRESH_RST;
      s.irq_mask <= `FFH_MASK_RST;
    end
    else
      s <= next_s;
  end

  // Outputs straight from flops
  // Nothing is decoded here, which keeps the pins free of glitches
  assign wb_dat_o                 = s.rdat;
  assign wb_ack_o                 = s.ack;
  assign fault_o                  = s.fault_pin;
  assign stop_procs_o             = s.halted;
  assign link_quiesce_o           = s.quiesce;
  assign out_fetch_inhibit_o      = s.fetch_inh;
  assign refresh_en_o             = s.refresh;
  assign areg_load_o              = s.areg_ld;
  assign areg_o                   = s.halt_ip;
  assign test_result_o            = s.tres;
  assign stop_on_fault_flag_o     = s.stop;
  assign breakpoint_enable_flag_o = s.bkpt;
  assign irq_o                    = s.irq;

endmodule

// ==== hdl/ffh_params.svh ====
/*
  Offsets, field positions, reset values and constants for the fault flag and
  halt control block. Assumes byte addresses on a 32-bit Wishbone bus.
*/
`ifndef FFH_PARAMS_SVH
`define FFH_PARAMS_SVH

// Register byte offsets
`define FFH_CTRL_OFF      8'h00
`define FFH_CMD_OFF       8'h04
`define FFH_STAT_OFF      8'h08
`define FFH_HALT_IP_OFF   8'h0c
`define FFH_IRQ_STAT_OFF  8'h10
`define FFH_IRQ_MASK_OFF  8'h14

// Control fields
`define FFH_CTRL_STOP     0
`define FFH_CTRL_BKPT     1
// Command fields (write only)
`define FFH_CMD_SET       0
`define FFH_CMD_TCLR      1
// Status fields
`define FFH_STAT_FAULT    0
`define FFH_STAT_STOP     1
`define FFH_STAT_HALTED   2
`define FFH_STAT_DBG      3
`define FFH_STAT_IDLE     4
`define FFH_STAT_TRES     5
// Interrupt fields
`define FFH_IRQ_FAULT     0
`define FFH_IRQ_HALT      1
`define FFH_IRQ_UPSTREAM  2
`define FFH_IRQ_W         3

// Instruction pointer offsets at halt
`define FFH_FAULT_IP_ADJ  32'h0000_0002
`define FFH_DBG_IP_ADJ    32'h0000_0001

// Reset values
`define FFH_REFRESH_RST   1'b1
`define FFH_MASK_RST      3'h0

`endif

// ==== hdl/ffh_pkg.sv ====
/*
  Types for the fault flag and halt control block.
  Assumes ffh_params.svh is included by the modules that need the constants.
*/
package ffh_pkg;

  // One-hot halt sequencer states
  typedef enum logic [3:0] {
    FFH_RUN      = 4'h1,
    FFH_WAIT_DS  = 4'h2,
    FFH_HALT_FLT = 4'h4,
    FFH_HALT_DBG = 4'h8
  } ffh_state_t;

endpackage

// ==== hdl/ffh_sync.sv ====
/*
  Two flip-flop synchroniser for a bus of asynchronous levels.
  Assumes the inputs are levels held longer than two clock periods.
*/
`timescale 1ns/1ns
module ffh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ffh_sync_t;

  ffh_sync_t s;
  ffh_sync_t next_s;

  // First stage feeds only the second stage
  always_comb
  begin
    next_s.meta = d_i;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign q_o = s.sync;

endmodule

// ==== hdl/ffh_save.sv ====
/*
  Holds the low priority fault and stop flags while a high priority process
  runs. Assumes save and restore are one-cycle pulses from the core, properly
  paired; a nested pre-emption cannot occur at the top priority level.
*/
`timescale 1ns/1ns
module ffh_save (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Save strobe, live flags in, held copies out
  input  wire logic save_i,
  input  wire logic fault_i,
  input  wire logic stop_i,
  output logic      fault_o,
  output logic      stop_o,
  output logic      held_o
);

  typedef struct packed {
    logic fault;
    logic stop;
    logic held;
  } ffh_save_t;

  ffh_save_t s;
  ffh_save_t next_s;

  // Capture on save; keep until the next save so restore reads a stable copy
  always_comb
  begin
    next_s = s;
    if (save_i)
    begin
      next_s.fault = fault_i;
      next_s.stop  = stop_i;
      next_s.held  = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign fault_o = s.fault;
  assign stop_o  = s.stop;
  assign held_o  = s.held;

endmodule

// ==== dv/ffh_up_model.sv ====
/*
  Upstream processor whose fault pin is chained into upstream_fault_in_i.
  Assumes set_i and clr_i come from the bench, changed just after clk_i rises.
*/
`timescale 1ns/1ns
module ffh_up_model (
  // Clock
  input  wire logic clk_i,
  // Upstream fault events
  input  wire logic set_i,
  input  wire logic clr_i,
  // Chained fault pin
  output logic      fault_o
);
  // Starts set: the power-up value is undefined, so the bench must clear it first
  logic flag = 1'b1;

  // Sticky flag, cleared only by its own test-and-clear
  always_ff @(posedge clk_i)
    flag <= set_i | (flag & ~clr_i);

  // Pin feeds the next processor in the chain
  assign fault_o = flag;
endmodule

// ==== dv/ffh_ctrl_checker.sv ====
/*
  Concurrent assertions on the ports of ffh_ctrl.
  Assumes one clock domain with the synchronous reset rst_i.
*/
`timescale 1ns/1ns
module ffh_ctrl_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Watched inputs
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        upstream_fault_in_i,
  input wire logic        debug_halt_i,
  input wire logic        proc_reset_i,
  input wire logic        ovf_i,
  input wire logic        div0_i,
  input wire logic        bounds_i,
  input wire logic        fpu_fault_i,
  input wire logic        core_set_i,
  input wire logic        test_clr_i,
  input wire logic        preempt_end_i,
  input wire logic        desched_i,
  input wire logic [31:0] ip_i,
  // Watched outputs
  input wire logic        fault_o,
  input wire logic        stop_procs_o,
  input wire logic        link_quiesce_o,
  input wire logic        out_fetch_inhibit_o,
  input wire logic        refresh_en_o,
  input wire logic        areg_load_o,
  input wire logic [31:0] areg_o,
  input wire logic        stop_on_fault_flag_o,
  input wire logic        breakpoint_enable_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Any core event that sets the fault flag
  logic any_set;
  assign any_set = ovf_i | div0_i | bounds_i | fpu_fault_i | core_set_i;

  // Steps of the two halt paths and of the pin path
  sequence s_up; upstream_fault_in_i[*3]; endsequence
  sequence s_dbg; debug_halt_i[*5] ##0 (desched_i && !stop_procs_o && !proc_reset_i && !any_set); endsequence
  sequence s_arm; stop_on_fault_flag_o && !fault_o && !stop_procs_o && !proc_reset_i && any_set; endsequence
  // A clear may come only from test-and-clear, a bus write or a restore
  sequence s_noclr; (!test_clr_i && !preempt_end_i && !(wb_stb_i && wb_we_i))[*3]; endsequence

  property p_pin; s_up |=> fault_o; endproperty
  property p_set; any_set |=> fault_o; endproperty
  property p_keep; any_set ##1 s_noclr |-> fault_o; endproperty
  property p_preset; any_set ##1 (proc_reset_i && !test_clr_i) |=> fault_o; endproperty
  property p_halt; s_arm |=> stop_procs_o && link_quiesce_o && areg_load_o && areg_o == $past(ip_i) + 32'h2;
  endproperty
  property p_nohalt; fault_o && !stop_procs_o && !any_set && !desched_i && !wb_stb_i && !preempt_end_i
    |=> !stop_procs_o; endproperty
  property p_dbg; s_dbg |=> stop_procs_o && out_fetch_inhibit_o && areg_load_o && areg_o == $past(ip_i) + 32'h1;
  endproperty
  property p_ref; stop_procs_o |-> refresh_en_o; endproperty
  property p_keepflags; debug_halt_i[*3] ##0 (proc_reset_i && !wb_stb_i && !preempt_end_i)
    |=> $stable(stop_on_fault_flag_o) && $stable(breakpoint_enable_flag_o); endproperty

  a_pin: assert property (p_pin)
    else $error("fault pin low while upstream held high");
  a_set: assert property (p_set)
    else $error("fault event did not raise fault pin");
  a_keep: assert property (p_keep)
    else $error("fault flag dropped without test and clear");
  a_preset: assert property (p_preset)
    else $error("processor reset cleared the fault flag");
  a_halt: assert property (p_halt)
    else $error("fault with stop armed gave wrong halt");
  a_nohalt: assert property (p_nohalt)
    else $error("halt without a fault flag rise");
  a_dbg: assert property (p_dbg)
    else $error("debug halt at descheduling point wrong");
  a_ref: assert property (p_ref)
    else $error("refresh stopped while halted");
  a_keepflags: assert property (p_keepflags)
    else $error("reset under debug halt changed flags");
endmodule

bind ffh_ctrl ffh_ctrl_checker chk (.clk_i, .rst_i, .wb_stb_i, .wb_we_i, .upstream_fault_in_i, .debug_halt_i,
  .proc_reset_i, .ovf_i, .div0_i, .bounds_i, .fpu_fault_i, .core_set_i, .test_clr_i, .preempt_end_i, .desched_i,
  .ip_i, .fault_o, .stop_procs_o, .link_quiesce_o, .out_fetch_inhibit_o, .refresh_en_o, .areg_load_o, .areg_o,
  .stop_on_fault_flag_o, .breakpoint_enable_flag_o);

// ==== dv/ffh_ctrl_tb.sv ====
/*
  Self-checking bench for ffh_ctrl with an upstream processor model.
  Assumes a 50 MHz clock and the register map of ffh_params.svh.
*/
`timescale 1ns/1ns
`include "ffh_params.svh"
module ffh_ctrl_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, dbg = 1'b0, busy = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, ip = 32'h0, q, rd, areg;
  logic [11:0] pl = 12'h800;
  logic        up, ack, flt, stp, quie, ofi, rfr, sof, bpe, irq, tres;
  int          error_cnt = 0, samples_checked = 0;
  localparam logic [11:0] m_tclr = 12'h020, m_pre = 12'h040, m_pend = 12'h080, m_des = 12'h100;
  localparam logic [11:0] m_prst = 12'h200, m_upset = 12'h400, m_upclr = 12'h800;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  ffh_up_model up_m (.clk_i(clk_i), .set_i(pl[10]), .clr_i(pl[11]), .fault_o(up));
  ffh_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .upstream_fault_in_i(up),
    .debug_halt_i(dbg), .fault_o(flt), .proc_reset_i(pl[9]), .ovf_i(pl[0]), .div0_i(pl[1]), .bounds_i(pl[2]),
    .fpu_fault_i(pl[3]), .core_set_i(pl[4]), .test_clr_i(pl[5]), .preempt_i(pl[6]), .preempt_end_i(pl[7]),
    .desched_i(pl[8]), .ip_i(ip), .links_busy_i(busy), .stop_procs_o(stp), .link_quiesce_o(quie),
    .out_fetch_inhibit_o(ofi), .refresh_en_o(rfr), .areg_load_o(), .areg_o(areg), .test_result_o(tres),
    .stop_on_fault_flag_o(sof), .breakpoint_enable_flag_o(bpe), .irq_o(irq));

  // Closing report
  task print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare one word against its expectation
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One classic Wishbone cycle; the bound catches a slave that never answers
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk_i);
    q = rd;
    {cyc, stb} <= 2'b00;
    if (n == 20)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Two back-to-back one-cycle pulses; entered just after a rising edge
  task pulse(input logic [11:0] a, input logic [11:0] b);
    pl <= a;
    @(posedge clk_i);
    pl <= b;
    @(posedge clk_i);
    pl <= 12'h000;
    @(posedge clk_i);
  endtask

  // Expected status word and halt pointer
  function automatic logic [31:0] stat(input logic f, s, h, d, i, t);
    return {26'h0, t, i, d, h, s, f};
  endfunction
  function automatic logic [31:0] halt_ip(input logic [31:0] p, input logic d);
    return p + (d ? 32'h1 : 32'h2);
  endfunction

  // Main sequence
  initial
  begin
    int i;
    logic [31:0] v;
    void'($urandom(10365));
    tick(16);
    rst_i <= 1'b0;
    pl <= 12'h000;
    rd_chk(`FFH_IRQ_MASK_OFF, 32'h0);
    rd_chk(8'h1c, 32'h0);
    v = $urandom & 32'h3;
    wb(1'b1, `FFH_CTRL_OFF, v);
    rd_chk(`FFH_CTRL_OFF, v);
    wb(1'b1, `FFH_CTRL_OFF, 32'h0);
    wb(1'b1, `FFH_IRQ_MASK_OFF, 32'h1);
    // Every fault source, then test-and-clear
    for (i = 0; i < 6; i++)
    begin
      if (i == 5)
        wb(1'b1, `FFH_CMD_OFF, 32'h1);
      else
        pulse(12'h001 << i, 12'h000);
      tick(1);
      chk(32'(flt), 32'h1);
      chk(32'(irq), 32'h1);
      rd_chk(`FFH_IRQ_STAT_OFF, 32'h1);
      tick(3);
      chk(32'(irq), 32'h0);
      chk(32'(flt), 32'h1);
      pulse(m_tclr, 12'h000);
      rd_chk(`FFH_STAT_OFF, stat(0, 0, 0, 0, 0, 1));
    end
    wb(1'b1, `FFH_IRQ_MASK_OFF, 32'h0);
    // Processor reset straight after a fault, then arming stop late
    pulse(12'h004, m_prst);
    chk(32'(flt), 32'h1);
    wb(1'b1, `FFH_CTRL_OFF, 32'h1);
    pulse(12'h001, 12'h000);
    chk(32'(stp), 32'h0);
    pulse(m_tclr, 12'h000);
    // Fault halt with stop armed and links still busy
    ip <= $urandom;
    busy <= 1'b1;
    pulse(12'h002, 12'h000);
    chk(32'(stp), 32'h1);
    chk(32'(quie), 32'h1);
    chk(32'(ofi), 32'h0);
    chk(areg, halt_ip(ip, 1'b0));
    chk(32'(rfr), 32'h1);
    rd_chk(`FFH_STAT_OFF, stat(1, 1, 1, 0, 0, 1));
    busy <= 1'b0;
    tick(1);
    rd_chk(`FFH_STAT_OFF, stat(1, 1, 1, 0, 1, 1));
    pulse(m_prst, m_tclr);
    chk(32'(stp), 32'h0);
    // Upstream fault reaches the pin but not the flag; its interrupt is masked
    rd_chk(`FFH_IRQ_STAT_OFF, 32'h3);
    pulse(m_upset, 12'h000);
    tick(2);
    chk(32'(flt), 32'h1);
    chk(32'(irq), 32'h0);
    rd_chk(`FFH_STAT_OFF, stat(0, 0, 0, 0, 0, 1));
    rd_chk(`FFH_IRQ_STAT_OFF, 32'h4);
    pulse(m_upclr, 12'h000);
    tick(2);
    chk(32'(flt), 32'h0);
    // Pre-emption: the high priority process changes both flags
    wb(1'b1, `FFH_CTRL_OFF, 32'h1);
    pulse(m_pre, 12'h000);
    chk(32'(sof), 32'h1);
    wb(1'b1, `FFH_CTRL_OFF, 32'h0);
    pulse(12'h008, m_pend);
    chk(32'(sof), 32'h1);
    chk(32'(flt), 32'h0);
    chk(32'(stp), 32'h0);
    // Debug halt at a descheduling point, then reset under it
    wb(1'b1, `FFH_CTRL_OFF, 32'h3);
    dbg <= 1'b1;
    tick(6);
    ip <= $urandom;
    pulse(m_des, 12'h000);
    chk(32'(stp), 32'h1);
    chk(32'(ofi), 32'h1);
    chk(areg, halt_ip(ip, 1'b1));
    rd_chk(`FFH_STAT_OFF, stat(0, 1, 1, 1, 1, 1));
    pulse(m_prst, 12'h000);
    rd_chk(`FFH_CTRL_OFF, 32'h3);
    chk(32'({sof, bpe}), 32'h3);
    dbg <= 1'b0;
    tick(3);
    pulse(m_prst, 12'h000);
    chk(32'(stp), 32'h0);
    // Test-and-clear on a clear flag reports zero
    pulse(m_tclr, 12'h000);
    chk(32'(tres), 32'h0);
    rd_chk(`FFH_STAT_OFF, stat(0, 0, 0, 0, 0, 0));
    print_verdict();
  end
endmodule
